// ### verilog/rs485_transceiver_direction_control.sv
// rs485 line driver and receiver enable control with mode register at port offset 7
`timescale 1ns/100ps
`include "rs485_dir_regs.svh"

module rs485_transceiver_direction_control
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic [2:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWriteData,
  output logic [7:0] ioReadData,
  output logic ioReadHit,
  input wire logic dataTerminalReady_n,
  input wire logic transmit_ready_indicator_n,
  output logic driverEnable,
  output logic receiverEnable,
  output logic [3:0] activeMode
);

  // ====================================================
  // access decode
  logic writeHit;
  logic readHit;

  always_comb
  begin
    writeHit = 1'b0;
    readHit = 1'b0;
    if (ioAddr == `MODE_SELECT_OFFSET)
    begin
      writeHit = ioWrite;
      readHit = ioRead;
    end
  end

  assign ioReadHit = readHit;

  // ====================================================
  // mode register
  logic [7:0] modeSelect_reg;
  logic [7:0] modeSelect_next;

  always_comb
  begin
    modeSelect_next = modeSelect_reg;
    if (writeHit)
    begin
      modeSelect_next = ioWriteData;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      modeSelect_reg <= `MODE_SELECT_RESET;
    end
    else if (clkEnable)
    begin
      modeSelect_reg <= modeSelect_next;
    end
  end

  // ====================================================
  // read data register
  logic [7:0] readData_reg;
  logic [7:0] readData_next;

  always_comb
  begin
    readData_next = readData_reg;
    if (readHit)
    begin
      readData_next = modeSelect_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      readData_reg <= 8'h00;
    end
    else if (clkEnable)
    begin
      readData_reg <= readData_next;
    end
  end

  assign ioReadData = readData_reg;

  // ====================================================
  // code recognition
  logic codeFourWire;
  logic codeDtrEcho;
  logic codeDtrControlled;
  logic codeAutoDirection;

  always_comb
  begin
    codeFourWire = 1'b0;
    codeDtrEcho = 1'b0;
    codeDtrControlled = 1'b0;
    codeAutoDirection = 1'b0;
    if (modeSelect_next == `MODE_CODE_FOUR_WIRE)
    begin
      codeFourWire = 1'b1;
    end
    if (modeSelect_next == `MODE_CODE_DTR_ECHO)
    begin
      codeDtrEcho = 1'b1;
    end
    if (modeSelect_next == `MODE_CODE_DTR_CONTROLLED)
    begin
      codeDtrControlled = 1'b1;
    end
    if (modeSelect_next == `MODE_CODE_AUTO_DIRECTION)
    begin
      codeAutoDirection = 1'b1;
    end
  end

  // ====================================================
  // decoded mode register
  rs485_dir_pkg::xcvr_mode_t mode_reg;
  rs485_dir_pkg::xcvr_mode_t mode_next;

  // decoded with the byte, no lag
  always_comb
  begin
    if (codeFourWire)
    begin
      mode_next = rs485_dir_pkg::MODE_FOUR_WIRE;
    end
    else if (codeDtrEcho)
    begin
      mode_next = rs485_dir_pkg::MODE_DTR_ECHO;
    end
    else if (codeDtrControlled)
    begin
      mode_next = rs485_dir_pkg::MODE_DTR_CONTROLLED;
    end
    else if (codeAutoDirection)
    begin
      mode_next = rs485_dir_pkg::MODE_AUTO_DIRECTION;
    end
    else
    begin
      mode_next = rs485_dir_pkg::MODE_FOUR_WIRE;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_reg <= rs485_dir_pkg::MODE_FOUR_WIRE;
    end
    else if (clkEnable)
    begin
      mode_reg <= mode_next;
    end
  end

  // ====================================================
  // active low control inputs
  logic dtrAsserted;
  logic txReadyAsserted;

  assign dtrAsserted = ~dataTerminalReady_n;
  assign txReadyAsserted = ~transmit_ready_indicator_n;

  // ====================================================
  // per-mode enable candidates
  logic echoDrive;
  logic echoListen;
  logic controlledDrive;
  logic controlledListen;
  logic autoDrive;
  logic autoListen;

  always_comb
  begin
    echoDrive = ~dtrAsserted;
    echoListen = 1'b1;
  end

  always_comb
  begin
    controlledDrive = ~dtrAsserted;
    controlledListen = dtrAsserted;
  end

  always_comb
  begin
    autoDrive = txReadyAsserted;
    autoListen = ~txReadyAsserted;
  end

  // ====================================================
  // enable select
  logic driveSel;
  logic listenSel;

  always_comb
  begin
    case (mode_reg)
      rs485_dir_pkg::MODE_FOUR_WIRE:
      begin
        driveSel = 1'b1;
        listenSel = 1'b1;
      end
      rs485_dir_pkg::MODE_DTR_ECHO:
      begin
        driveSel = echoDrive;
        listenSel = echoListen;
      end
      rs485_dir_pkg::MODE_DTR_CONTROLLED:
      begin
        driveSel = controlledDrive;
        listenSel = controlledListen;
      end
      rs485_dir_pkg::MODE_AUTO_DIRECTION:
      begin
        driveSel = autoDrive;
        listenSel = autoListen;
      end
      default:
      begin
        driveSel = 1'b1;
        listenSel = 1'b1;
      end
    endcase
  end

  // ====================================================
  // outputs
  assign driverEnable = driveSel;
  assign receiverEnable = listenSel;
  assign activeMode = mode_reg;

endmodule

// ### include/rs485_dir_regs.svh
// register offsets, reset values and mode codes for the transceiver direction control
`ifndef RS485_DIR_REGS_SVH
`define RS485_DIR_REGS_SVH
`define MODE_SELECT_OFFSET 3'h7
`define MODE_SELECT_RESET 8'h00
`define MODE_CODE_FOUR_WIRE 8'h00
`define MODE_CODE_DTR_ECHO 8'h01
`define MODE_CODE_DTR_CONTROLLED 8'h02
`define MODE_CODE_AUTO_DIRECTION 8'h03
`endif

// ### include/rs485_dir_pkg.sv
// types for the transceiver direction control
package rs485_dir_pkg;
  typedef enum logic [3:0]
  {
    MODE_FOUR_WIRE = 4'h1,
    MODE_DTR_ECHO = 4'h2,
    MODE_DTR_CONTROLLED = 4'h4,
    MODE_AUTO_DIRECTION = 4'h8
  } xcvr_mode_t;
endpackage

// ### verif/rs485_dir_chk.sv
// checker for the transceiver direction control ports
`timescale 1ns/100ps
module rs485_dir_chk
(
  input wire logic ref_clk, reset, clkEnable, ioWrite, ioRead, ioReadHit,
  input wire logic dataTerminalReady_n, transmit_ready_indicator_n, driverEnable, receiverEnable,
  input wire logic [2:0] ioAddr,
  input wire logic [7:0] ioWriteData, ioReadData,
  input wire logic [3:0] activeMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========
  // enable relations
  chk_four_wire_on: assert property (activeMode == 4'h1 |-> driverEnable && receiverEnable) else $error("4w");
  chk_echo_drive: assert property (activeMode == 4'h2 |-> driverEnable == dataTerminalReady_n) else $error("echo");
  chk_echo_path: assert property (activeMode == 4'h2 && driverEnable |-> receiverEnable) else $error("echo rx");
  chk_dtr_exclusive: assert property (activeMode == 4'h4 |->
    driverEnable == dataTerminalReady_n && receiverEnable == !dataTerminalReady_n) else $error("dtr");
  chk_auto_direction: assert property (activeMode == 4'h8 |->
    driverEnable == !transmit_ready_indicator_n && receiverEnable == transmit_ready_indicator_n) else $error("auto");
  // ==========
  // register access
  chk_mode_write: assert property (ioWrite && clkEnable && ioAddr == 3'h7 |=>
    activeMode == ($past(ioWriteData) > 8'h03 ? 4'h1 : 4'h1 << $past(ioWriteData[1:0]))) else $error("mode");
  chk_frozen_mode: assert property (!clkEnable |=> $stable(activeMode)) else $error("frozen");
  chk_read_hit: assert property (ioReadHit == (ioRead && ioAddr == 3'h7)) else $error("hit");
endmodule

// ### verif/rs485_bus_model.sv
// line-side model: own bytes heard back while both enables on
`timescale 1ns/100ps
module rs485_bus_model
(
  input wire logic driverEnable,
  input wire logic receiverEnable,
  output logic echoSeen
);
  assign echoSeen = driverEnable & receiverEnable;
endmodule

// ### verif/rs485_transceiver_direction_control_tb_top.sv
// testbench for the transceiver direction control
`timescale 1ns/100ps
module rs485_transceiver_direction_control_tb_top;
  logic ref_clk = 0, reset = 1, clkEnable = 1, ioWrite = 0, ioRead = 0;
  logic dataTerminalReady_n = 1, transmit_ready_indicator_n = 1;
  logic [2:0] ioAddr = 3'h7;
  logic [7:0] ioWriteData = 8'h00;
  logic [7:0] ioReadData;
  logic [3:0] activeMode;
  logic ioReadHit, driverEnable, receiverEnable, echoSeen;
  int error_cnt = 0, comparisons = 0;
  rs485_transceiver_direction_control dut_u (.*);
  rs485_bus_model bus_u (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task chk(input logic [7:0] a, input logic [7:0] e);
    comparisons++;
    if (a !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, a, e);
    end
  endtask
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk) {ioWrite, ioRead, ioAddr, ioWriteData} <= {w, !w, a, d};
    @(posedge ref_clk) {ioWrite, ioRead} <= 2'b00;
    #1;
  endtask
  task stop_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task test_reset;
    chk({driverEnable, receiverEnable, activeMode}, 8'h31);
    acc(0, 3'h7, 8'h00);
    chk(ioReadData, 8'h00);
  endtask
  task test_modes;
    logic [7:0] e;
    for (int m = 0; m < 5; m++)
      for (int i = 0; i < 4; i++)
      begin
        acc(1, 3'h7, 8'(m));
        @(posedge ref_clk) {dataTerminalReady_n, transmit_ready_indicator_n} <= 2'(i);
        #1;
        e = m == 1 ? {1'b0, i[1], 1'b1} : m == 2 ? {1'b0, i[1], !i[1]} : m == 3 ? {1'b0, !i[0], i[0]} : 8'h03;
        chk({driverEnable, receiverEnable}, e);
        chk(echoSeen, e[1] & e[0]);
        chk(activeMode, m == 4 ? 8'h01 : 8'h01 << m);
      end
  endtask
  task test_access;
    acc(1, 3'h7, 8'h5a);
    acc(1, 3'h3, 8'h02);
    @(posedge ref_clk) clkEnable <= 0;
    acc(1, 3'h7, 8'h03);
    @(posedge ref_clk) clkEnable <= 1;
    acc(0, 3'h7, 8'h00);
    chk(ioReadData, 8'h5a);
    chk(activeMode, 4'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 0;
    #2 test_reset;
    test_modes;
    test_access;
    stop_test;
  end
  initial
  begin
    #20000 error_cnt++;
    stop_test;
  end
endmodule
bind rs485_transceiver_direction_control rs485_dir_chk chk_u (.*);
